// ### core/motor_timer.sv
`timescale 1ns/1ps
`include "mt_regs.svh"

// Contract
// (R1) One 16-bit counter counts up, down or up/down with auto-reload.
// (R2) Prescaler divides timer clock by any factor 1 to 65536.
// (R3) Four 16-bit capture/compare values, capture or compare per channel.
// (R4) A 16-bit reload value sets the counting period.
// (R5) An 8-bit repetition counter delays update events by N periods.
// (R6) Input capture latches counter; compare match toggles channel output.
// (R7) PWM in edge-aligned or centre-aligned counting mode.
// (R8) Single-pulse mode stops counting after one period; code stops at the next update event, which repetition can delay.
// (R9) Complementary outputs with programmable dead time between edges.
// (R10) Break input forces outputs to a programmed safe level.
// (R11) Flags on update, capture, match; individually enabled interrupt.
module mt_motor_timer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Counter control
  input  wire logic        enable,
  input  wire logic [1:0]  count_mode,
  input  wire logic        single_pulse,
  input  wire logic [15:0] prescale,
  input  wire logic [15:0] counter_reload_value,
  input  wire logic [7:0]  repetition,
  // Channel control
  input  wire logic [7:0]  channel_mode,
  input  wire logic [63:0] compare_in,
  input  wire logic [3:0]  compare_load,
  input  wire logic [3:0]  capture_in,
  input  wire logic [7:0]  dead_time,
  // Break
  input  wire logic        brk_in,
  input  wire logic [3:0]  safe_level,
  input  wire logic [3:0]  safe_level_n,
  // Flags
  input  wire logic [4:0]  flag_clear,
  input  wire logic [4:0]  irq_enable,
  // Outputs
  output logic [15:0]      count,
  output logic [63:0]      capture_compare_value,
  output logic [4:0]       flags,
  output logic             irq,
  output logic             running,
  output logic [3:0]       ch_out,
  output logic [3:0]       ch_out_n
);

  // ---------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------
  logic [15:0] pre_cnt;
  logic        tick;
  logic        dir_down;
  logic [7:0]  rep_cnt;
  logic        period_end;
  logic        update_ev;
  logic [3:0]  cap_d;
  logic [3:0]  raw;
  logic [3:0]  raw_d;
  logic [7:0]  dt_cnt [4];
  logic [3:0]  match;
  logic [3:0]  cap_ev;
  logic [4:0]  ev;
  mt_pkg::mt_run_type run_state;
  logic        spent;

  assign tick = (pre_cnt == prescale) && running; // R2

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pre_cnt <= 16'h0000;
    end else if (!running || tick) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  always_comb begin
    case (count_mode)
      `MT_MODE_UP:     period_end = (count == counter_reload_value);
      `MT_MODE_DOWN:   period_end = (count == 16'h0000);
      `MT_MODE_CENTER: period_end = dir_down && (count == 16'h0001);
      default:         period_end = (count == counter_reload_value);
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count    <= 16'h0000;
      dir_down <= 1'b0;
    end else if (tick) begin
      case (count_mode)
        `MT_MODE_DOWN: begin
          count <= period_end ? counter_reload_value // R1 R4
                              : count - 16'h0001;
        end
        `MT_MODE_CENTER: begin
          if (!dir_down && count >= counter_reload_value - 16'h0001) begin
            dir_down <= 1'b1; // R7
            count    <= counter_reload_value;
          end else if (dir_down && count <= 16'h0001) begin
            dir_down <= 1'b0;
            count    <= 16'h0000;
          end else begin
            count <= dir_down ? count - 16'h0001 : count + 16'h0001;
          end
        end
        default: begin
          count <= period_end ? 16'h0000 : count + 16'h0001; // R1 R4
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Repetition and run control
  // ---------------------------------------------------------------
  assign update_ev = tick && period_end && (rep_cnt == 8'h00); // R5

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rep_cnt <= `MT_REP_RST;
    end else if (tick && period_end) begin
      rep_cnt <= (rep_cnt == 8'h00) ? repetition : rep_cnt - 8'h01; // R5
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      run_state <= mt_pkg::MT_RUN_IDLE;
      running   <= 1'b0;
    end else begin
      case (run_state)
        mt_pkg::MT_RUN_IDLE: begin
          if (enable && !spent) begin // R8
            run_state <= mt_pkg::MT_RUN_BUSY;
            running   <= 1'b1;
          end
        end
        mt_pkg::MT_RUN_BUSY: begin
          if (!enable || (single_pulse && update_ev)) begin
            run_state <= mt_pkg::MT_RUN_IDLE; // R8
            running   <= 1'b0;
          end
        end
        default: begin
          run_state <= mt_pkg::MT_RUN_IDLE;
          running   <= 1'b0;
        end
      endcase
    end
  end

  // Single pulse spent, held until enable drops
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      spent <= 1'b0;
    end else if (!enable) begin
      spent <= 1'b0;
    end else if (running && single_pulse && update_ev) begin
      spent <= 1'b1; // R8
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cap_d <= 4'h0;
    end else begin
      cap_d <= capture_in;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ch
      logic [1:0]  md;
      logic [15:0] cv;
      assign md = channel_mode[2*g +: 2];
      assign cv = capture_compare_value[16*g +: 16];
      assign match[g]  = tick && (md != `MT_CH_CAPTURE) && (count == cv);
      assign cap_ev[g] = (md == `MT_CH_CAPTURE) && capture_in[g]
                         && !cap_d[g];

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          capture_compare_value[16*g +: 16] <= `MT_CMP_RST;
        end else if (cap_ev[g]) begin
          capture_compare_value[16*g +: 16] <= count; // R3 R6
        end else if (compare_load[g]) begin
          capture_compare_value[16*g +: 16] <= compare_in[16*g +: 16]; // R3
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          raw[g] <= 1'b0;
        end else if (md == `MT_CH_PWM) begin
          raw[g] <= (count < cv); // R7
        end else if (match[g]) begin
          raw[g] <= ~raw[g]; // R6
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          raw_d[g]  <= 1'b0;
          dt_cnt[g] <= `MT_DEAD_RST;
        end else begin
          raw_d[g] <= raw[g];
          if (raw[g] != raw_d[g]) begin
            dt_cnt[g] <= dead_time; // R9
          end else if (dt_cnt[g] != 8'h00) begin
            dt_cnt[g] <= dt_cnt[g] - 8'h01;
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          ch_out[g]   <= 1'b0;
          ch_out_n[g] <= 1'b0;
        end else if (brk_in) begin
          ch_out[g]   <= safe_level[g]; // R10
          ch_out_n[g] <= safe_level_n[g];
        end else begin
          ch_out[g]   <= raw_d[g] && (dt_cnt[g] == 8'h00); // R9
          ch_out_n[g] <= !raw_d[g] && (dt_cnt[g] == 8'h00);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Flags and interrupt
  // ---------------------------------------------------------------
  assign ev = {match | cap_ev, update_ev};

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flags <= 5'h00;
    end else begin
      flags <= (flags & ~flag_clear) | ev; // R11
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((flags & ~flag_clear) | ev) & irq_enable); // R11
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_prescale;
    @(posedge ref_clk) disable iff (!nrst)
    (running && !tick && $past(running)) |=> $stable(count);
  endproperty
  a_prescale: assert property (p_prescale) else $error("count moved"); // R2

  property p_up_wrap;
    @(posedge ref_clk) disable iff (!nrst)
    (tick && count_mode == `MT_MODE_UP && period_end) |=> count == 16'h0000;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("no wrap"); // R1

  property p_down_reload;
    @(posedge ref_clk) disable iff (!nrst)
    (tick && count_mode == `MT_MODE_DOWN && count == 16'h0000)
      |=> count == $past(counter_reload_value);
  endproperty
  a_down_reload: assert property (p_down_reload) else $error("no reload"); // R4

  property p_capture;
    @(posedge ref_clk) disable iff (!nrst)
    cap_ev[0] |=> capture_compare_value[15:0] == $past(count);
  endproperty
  a_capture: assert property (p_capture) else $error("no capture"); // R3

  property p_flag;
    @(posedge ref_clk) disable iff (!nrst)
    update_ev |=> flags[`MT_EV_UPDATE];
  endproperty
  a_flag: assert property (p_flag) else $error("flag lost"); // R11

  property p_single;
    @(posedge ref_clk) disable iff (!nrst)
    (running && single_pulse && update_ev) |=> !running;
  endproperty
  a_single: assert property (p_single) else $error("kept running"); // R8

  property p_spent;
    @(posedge ref_clk) disable iff (!nrst)
    (spent && enable) |=> !running;
  endproperty
  a_spent: assert property (p_spent) else $error("pulse restarted"); // R8

  property p_break;
    @(posedge ref_clk) disable iff (!nrst)
    brk_in |=> ch_out == $past(safe_level) && ch_out_n == $past(safe_level_n);
  endproperty
  a_break: assert property (p_break) else $error("break ignored"); // R10

  property p_overlap;
    @(posedge ref_clk) disable iff (!nrst)
    !$past(brk_in) |-> (ch_out & ch_out_n) == 4'h0;
  endproperty
  a_overlap: assert property (p_overlap) else $error("pair overlap"); // R9

  property p_rep;
    @(posedge ref_clk) disable iff (!nrst)
    (tick && period_end && rep_cnt != 8'h00) |-> !update_ev;
  endproperty
  a_rep: assert property (p_rep) else $error("early update"); // R5

endmodule

// ### core/mt_pkg.sv
package mt_pkg;

  typedef enum logic [1:0] {
    MT_COUNT_UP     = 2'h0,
    MT_COUNT_DOWN   = 2'h1,
    MT_COUNT_CENTER = 2'h2
  } mt_mode_type;

  typedef enum logic [1:0] {
    MT_RUN_IDLE = 2'h1,
    MT_RUN_BUSY = 2'h2
  } mt_run_type;

endpackage

// ### core/mt_regs.svh
`ifndef MT_REGS_SVH
`define MT_REGS_SVH

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define MT_PRESCALE_RST 16'h0000
`define MT_RELOAD_RST   16'hFFFF
`define MT_CMP_RST      16'h0000
`define MT_REP_RST      8'h00
`define MT_DEAD_RST     8'h00

// ---------------------------------------------------------------
// Count mode codes
// ---------------------------------------------------------------
`define MT_MODE_UP      2'h0
`define MT_MODE_DOWN    2'h1
`define MT_MODE_CENTER  2'h2

// ---------------------------------------------------------------
// Channel mode codes
// ---------------------------------------------------------------
`define MT_CH_CAPTURE   2'h0
`define MT_CH_MATCH     2'h1
`define MT_CH_PWM       2'h2

// ---------------------------------------------------------------
// Event flag positions
// ---------------------------------------------------------------
`define MT_EV_UPDATE    0
`define MT_EV_CH0       1
`define MT_EV_WIDTH     5

`endif

// ### sim/mt_motor_timer_bench.sv
`timescale 1ns/1ps
module mt_motor_timer_bench;
  logic ref_clk = 1'b0, nrst = 1'b0, enable = 1'b0, single_pulse = 1'b0;
  logic [1:0] count_mode = 2'h0;
  logic [15:0] prescale = 16'h0, reload = 16'h0, count;
  logic [7:0] repetition = 8'h0, channel_mode = 8'h0, dead_time = 8'h0;
  logic [63:0] compare_in = 64'h0, ccv;
  logic [3:0] compare_load = 4'h0, capture_in, ch_out, ch_out_n;
  logic [3:0] safe_level = 4'h5, safe_level_n = 4'hA, hall_req = 4'h0;
  logic [4:0] flag_clear = 5'h0, irq_enable = 5'h0, flags;
  logic brk_in, brk_req = 1'b0, irq, running, shoot;
  int fails = 0, tests_run = 0;

  always #5 ref_clk = ~ref_clk;

  mt_motor_timer mt_motor_timer_inst (.ref_clk(ref_clk), .nrst(nrst),
    .enable(enable), .count_mode(count_mode), .single_pulse(single_pulse),
    .prescale(prescale), .counter_reload_value(reload),
    .repetition(repetition), .channel_mode(channel_mode),
    .compare_in(compare_in), .compare_load(compare_load),
    .capture_in(capture_in), .dead_time(dead_time), .brk_in(brk_in),
    .safe_level(safe_level), .safe_level_n(safe_level_n),
    .flag_clear(flag_clear), .irq_enable(irq_enable), .count(count),
    .capture_compare_value(ccv), .flags(flags), .irq(irq),
    .running(running), .ch_out(ch_out), .ch_out_n(ch_out_n));

  mt_power_stage mt_power_stage_inst (.ref_clk(ref_clk), .ch_out(ch_out),
    .ch_out_n(ch_out_n), .capture_in(capture_in), .brk_in(brk_in),
    .hall_req(hall_req), .brk_req(brk_req), .shoot(shoot));

  // ---------------------------------------
  // Helpers
  // ---------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic restart();
    enable = 1'b0;
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    while (flags[b] !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    if (n >= 5000) fails++;
  endtask

  // Cycles from one update flag to the next
  task automatic period(output int n);
    flag_clear = 5'h01;
    n = 0;
    do begin
      tick(1);
      flag_clear = 5'h00;
      n++;
    end while (flags[0] !== 1'b1 && n < 5000);
    if (flags[0] !== 1'b1) fails++;
  endtask

  task automatic load_cmp(input int g, input logic [15:0] v);
    compare_in[16*g +: 16] = v;
    compare_load = 4'h1 << g;
    tick(1);
    compare_load = 4'h0;
    tick(1);
  endtask

  function automatic int exp_period(int m, int rl, int ps, int rp);
    if (m == 2) return 2 * rl * (ps + 1) * (rp + 1);
    return (rl + 1) * (ps + 1) * (rp + 1);
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    fails++;
    test_done();
  end

  // ---------------------------------------
  // Tests
  // ---------------------------------------
  initial begin
    int n, hi, lo, cv, dt, tg;
    void'($urandom(32'h51294528));
    tick(16);
    nrst = 1'b1;
    tick(1);
    check({count, flags, irq, running, ch_out, ch_out_n}, {27'h0, 4'hF});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      restart();
      count_mode = 2'(i % 3);
      reload = 16'(4 + $urandom % 16);
      prescale = 16'($urandom % 4);
      repetition = 8'($urandom % 3);
      irq_enable = 5'h01;
      enable = 1'b1;
      wait_flag(0);
      check(irq, 1'b1);
      period(n);
      check(n, exp_period(i % 3, reload, prescale, repetition));
    end
    $display("test period done");
    restart();
    {count_mode, prescale, repetition, reload} = {2'h0, 16'h0, 8'h0, 16'h8};
    single_pulse = 1'b1;
    enable = 1'b1;
    wait_flag(0);
    tick(2);
    n = count;
    check(running, 1'b0);
    tick(5);
    check(count, n);
    single_pulse = 1'b0;
    $display("test single pulse done");
    restart();
    {channel_mode, prescale, reload} = {8'h00, 16'h3F, 16'h0FFF};
    enable = 1'b1;
    tick(100);
    hall_req = 4'h1;
    tick(4);
    check(flags[1], 1'b1);
    check((count - ccv[15:0]) <= 16'h1, 1'b1);
    hall_req = 4'h0;
    $display("test capture done");
    restart();
    {channel_mode, prescale, reload} = {8'h12, 16'h0, 16'h13};
    dt = 1 + $urandom % 3;
    cv = 6 + $urandom % 5;
    dead_time = 8'(dt);
    load_cmp(0, 16'(cv));
    load_cmp(2, 16'h5);
    enable = 1'b1;
    wait_flag(0);
    hi = 0;
    lo = 0;
    tg = 0;
    for (int k = 0; k < 20; k++) begin
      tick(1);
      hi += ch_out[0];
      lo += ch_out_n[0];
      tg += ch_out[2];
      tg += ch_out_n[2];
    end
    check(hi, cv - dt);
    check(lo, 20 - cv - dt);
    check(flags[3], 1'b1);
    check(tg, 20 - dt);
    check(shoot, 1'b0);
    brk_req = 1'b1;
    tick(4);
    check({ch_out, ch_out_n}, {safe_level, safe_level_n});
    brk_req = 1'b0;
    $display("test pwm and break done");
    test_done();
  end
endmodule

// ### sim/mt_power_stage.sv
`timescale 1ns/1ps
// ------------------------------------------
// Power stage, hall sensors and break source
// ------------------------------------------
module mt_power_stage (
  // Clock
  input  wire logic [0:0] ref_clk,
  // Timer side
  input  wire logic [3:0] ch_out,
  input  wire logic [3:0] ch_out_n,
  output logic [3:0]      capture_in,
  output logic            brk_in,
  // Bench side
  input  wire logic [3:0] hall_req,
  input  wire logic       brk_req,
  output logic            shoot
);
  initial begin
    capture_in = 4'h0;
    brk_in     = 1'b0;
    shoot      = 1'b0;
  end
  always @(negedge ref_clk) begin
    capture_in <= hall_req;
    brk_in     <= brk_req;
    if ((ch_out & ch_out_n) != 4'h0) begin
      shoot <= 1'b1;
    end
  end
endmodule
